//--- rtl/wse_event_logic.v
/*
  Wake and management-interrupt event logic: status/enable registers,
  pin edge capture, group management interrupt, wake output and the
  runtime register block decode on the host I/O strobes.
  Assumes single-cycle synchronous I/O strobes, reset_n from the standby
  supply power-on, and configuration values held stable by their owner.
*/
//
// Contract
// - Group interrupt is OR of every enabled device and pin event.
// - Polarity bit 2 of config1 picks management pin level; default low.
// - Management pin driver follows the driver-type configuration.
// - Group interrupt reaches the pin only while pin-route bit set.
// - Stream-route bit also reports group interrupt in IRQ2 slot.
// - Pin status sets on rising edge, or falling when inverted.
// - Pin interrupt status clears only on host write of one.
// - Pin interrupt request uses latched status AND enable.
// - Device status mirrors sources; writing one does not clear.
// - Device events gated live with enables, no latching.
// - Wake events from ring inputs and programmed pin edges.
// - Wake pin polarity from config2 bit 5; default active low.
// - Wake pin driver type from driver-type config bit 7.
// - Wake pin asserts only with global wake enable set.
// - Summary wake status sets regardless of global enable.
// - Summary stays set while any enabled source bit pending.
// - Decode uses base, compares bits 11:0, bits 15:12 zero.
// - Base on 16-byte bounds; decodes off when base below 0x100.
// - Registers reset only at standby power-on, not hard reset.
// - Reserved bits read zero.
// - Printer status reads one unpowered, else follows acknowledge.
// - Writing one to summary clears it unless a source is pending; zero does nothing.
`timescale 1ns/10ps
`default_nettype none
`include "wse_consts.vh"

module wse_event_logic (
  // Clock and standby power-on reset
  input wire clk,
  input wire reset_n,
  // Bus hard reset, kept apart from the runtime registers
  input wire bus_hard_reset_in,
  // Host I/O access
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata_ff,
  output reg io_hit_ff,
  // Configuration values
  input wire [11:0] runtime_base_config,
  input wire [7:0] gpio_polarity_config1,
  input wire [7:0] gpio_polarity_config2,
  input wire [7:0] gpio_polarity_config3,
  input wire [7:0] gpio_driver_type_config,
  input wire shared_mgmt_pin_sel,
  // Event sources
  input wire [31:0] gpio_in,
  input wire ring_indicator_a_n,
  input wire ring_indicator_b_n,
  input wire printer_port_powered,
  input wire printer_acknowledge_in,
  input wire uart_a_irq,
  input wire uart_b_irq,
  input wire floppy_irq,
  // Outputs
  output reg [31:0] gpio_out_ff,
  output reg mgmt_irq_group_ff,
  output reg irq2_slot_req_ff,
  output reg shared_mgmt_pin_out_ff,
  output reg shared_mgmt_pin_oe_ff,
  output reg wake_out_pin_out_ff,
  output reg wake_out_pin_oe_ff
);

  // ****************************************
  // Decode
  // ****************************************
  // Returns {hit, offset}; the block spans base..base+15 plus one
  // register far above it, hence a compare rather than a mask.
  function [8:0] wse_decode;
    input [15:0] addr;
    input [11:0] base;
    reg [12:0] diff;
    begin
      // Extra top bit marks an address below the base, so no wrap can hit
      diff = {1'b0, addr[11:0]} - {1'b0, base[11:4], 4'h0};
      if (addr[15:12] != 4'h0 || base < `WSE_BASE_MIN) begin
        wse_decode = 9'h000;
      end else if (diff[12:4] == 9'h000) begin
        wse_decode = {1'b1, diff[7:0]};
      end else if (diff[7:0] == `WSE_OFF_MEN1 && diff[12:8] == 5'h00) begin
        wse_decode = {1'b1, diff[7:0]};
      end else begin
        wse_decode = 9'h000;
      end
    end
  endfunction

  wire [8:0] dec;
  wire hit;
  wire [7:0] off;
  wire wr_hit;
  assign dec = wse_decode(io_addr, runtime_base_config);
  assign hit = dec[8];
  assign off = dec[7:0];
  assign wr_hit = io_wr & hit;

  // ****************************************
  // Write strobes
  // ****************************************
  wire we_wake_gen;
  wire we_wen1;
  wire we_wen2;
  wire we_wen3;
  wire we_men1;
  wire we_men2;
  wire we_gp1;
  wire we_gp2;
  wire we_gp3;
  wire we_gp4;
  assign we_wake_gen = wr_hit && off == `WSE_OFF_WAKE_GEN;
  assign we_wen1 = wr_hit && off == `WSE_OFF_WEN1;
  assign we_wen2 = wr_hit && off == `WSE_OFF_WEN2;
  assign we_wen3 = wr_hit && off == `WSE_OFF_WEN3;
  assign we_men1 = wr_hit && off == `WSE_OFF_MEN1;
  assign we_men2 = wr_hit && off == `WSE_OFF_MEN2;
  assign we_gp1 = wr_hit && off == `WSE_OFF_GP1;
  assign we_gp2 = wr_hit && off == `WSE_OFF_GP2;
  assign we_gp3 = wr_hit && off == `WSE_OFF_GP3;
  assign we_gp4 = wr_hit && off == `WSE_OFF_GP4;

  // ****************************************
  // Registers
  // ****************************************
  reg wake_sum_ff;
  reg wake_gen_ff;
  reg [7:0] wsts1_ff;
  reg [6:0] wsts2_ff;
  reg [7:0] wsts3_ff;
  reg [7:0] wen1_ff;
  reg [6:0] wen2_ff;
  reg [7:0] wen3_ff;
  reg [7:0] msts1_ff;
  reg [1:0] msts2_pin_ff;
  reg [7:0] men1_ff;
  reg [7:0] men2_ff;
  reg [31:0] gp_prev_ff;
  reg [1:0] ring_prev_ff;

  // ****************************************
  // Edge capture
  // ****************************************
  // Polarity bit set inverts the pin, turning a falling edge into a rise
  wire [31:0] gp_eff;
  wire [31:0] gp_rise;
  wire ring_a_evt;
  wire ring_b_evt;
  assign gp_eff = gpio_in ^ {8'h00, gpio_polarity_config3,
    gpio_polarity_config2, gpio_polarity_config1};
  assign gp_rise = gp_eff & ~gp_prev_ff;
  // Ring inputs are active low: the falling edge is the event
  assign ring_a_evt = ring_prev_ff[0] & ~ring_indicator_a_n;
  assign ring_b_evt = ring_prev_ff[1] & ~ring_indicator_b_n;

  // ****************************************
  // Live device sources
  // ****************************************
  wire printer_sts;
  wire [3:0] dev_sts;
  assign printer_sts = printer_port_powered ? printer_acknowledge_in
    : 1'b1;
  assign dev_sts = {floppy_irq, uart_a_irq, uart_b_irq, printer_sts};

  wire [7:0] msts2_view;
  assign msts2_view = {2'b00, msts2_pin_ff, dev_sts};

  // ****************************************
  // Next state of latched status
  // ****************************************
  // Set wins over a same-cycle write-one clear
  wire [7:0] nxt_wsts1;
  wire [6:0] nxt_wsts2;
  wire [7:0] nxt_wsts3;
  wire [7:0] nxt_msts1;
  wire [1:0] nxt_msts2_pin;
  wire [7:0] clr_w1;
  wire [7:0] clr_w2;
  wire [7:0] clr_w3;
  wire [7:0] clr_m1;
  wire [7:0] clr_m2;
  wire [7:0] clr_sum;
  assign clr_w1 = (wr_hit && off == `WSE_OFF_WSTS1) ? io_wdata : 8'h00;
  assign clr_w2 = (wr_hit && off == `WSE_OFF_WSTS2) ? io_wdata : 8'h00;
  assign clr_w3 = (wr_hit && off == `WSE_OFF_WSTS3) ? io_wdata : 8'h00;
  assign clr_m1 = (wr_hit && off == `WSE_OFF_MSTS1) ? io_wdata : 8'h00;
  assign clr_m2 = (wr_hit && off == `WSE_OFF_MSTS2) ? io_wdata : 8'h00;
  assign clr_sum = (wr_hit && off == `WSE_OFF_WAKE_SUM) ? io_wdata : 8'h00;

  assign nxt_wsts1 = gp_rise[7:0] | (wsts1_ff & ~clr_w1);
  assign nxt_wsts2 = {ring_b_evt, ring_a_evt, gp_rise[12:8]} |
    (wsts2_ff & ~clr_w2[6:0]);
  assign nxt_wsts3 = gp_rise[23:16] | (wsts3_ff & ~clr_w3);
  assign nxt_msts1 = gp_rise[7:0] | (msts1_ff & ~clr_m1);
  // Only the pin bits of bank 2 respond to write-one
  assign nxt_msts2_pin = gp_rise[12:11] |
    (msts2_pin_ff & ~clr_m2[`WSE_M2_GP24:`WSE_M2_GP23]);

  // ****************************************
  // Wake summary
  // ****************************************
  wire wake_pending;
  wire nxt_wake_sum;
  assign wake_pending = |(wsts1_ff & wen1_ff) | |(wsts2_ff & wen2_ff) |
    |(wsts3_ff & wen3_ff);
  // Pending sources hold the summary up even against a clear
  assign nxt_wake_sum = wake_pending |
    (wake_sum_ff & ~clr_sum[0]);

  // ****************************************
  // Group management interrupt
  // ****************************************
  wire nxt_group;
  assign nxt_group = |(msts1_ff & men1_ff) |
    |(msts2_pin_ff & men2_ff[`WSE_M2_GP24:`WSE_M2_GP23]) |
    |(dev_sts & men2_ff[`WSE_M2_FLOPPY:`WSE_M2_PRINTER]);

  // ****************************************
  // Pin drive
  // ****************************************
  // Returns {out, oe}; open drain only ever pulls low
  function [1:0] wse_drive;
    input active;
    input act_high;
    input push_pull;
    reg lvl;
    begin
      lvl = active ? act_high : ~act_high;
      wse_drive = push_pull ? {lvl, 1'b1} : {1'b0, ~lvl};
    end
  endfunction

  wire [1:0] mgmt_drv;
  wire [1:0] wake_drv;
  assign mgmt_drv = wse_drive(
    mgmt_irq_group_ff & men2_ff[`WSE_M2_PIN_ROUTE],
    gpio_polarity_config1[`WSE_POL1_MGMT_PIN],
    gpio_driver_type_config[`WSE_DRV_MGMT_PIN]);
  assign wake_drv = wse_drive(
    wake_sum_ff & wake_gen_ff,
    gpio_polarity_config2[`WSE_POL2_WAKE_PIN],
    gpio_driver_type_config[`WSE_DRV_WAKE_PIN]);

  // ****************************************
  // Read mux
  // ****************************************
  reg [7:0] nxt_rdata;
  always @* begin
    nxt_rdata = 8'h00;
    case (off)
      `WSE_OFF_WAKE_SUM: nxt_rdata = {7'h00, wake_sum_ff};
      `WSE_OFF_WAKE_GEN: nxt_rdata = {7'h00, wake_gen_ff};
      `WSE_OFF_WSTS1: nxt_rdata = wsts1_ff;
      `WSE_OFF_WSTS2: nxt_rdata = {1'b0, wsts2_ff};
      `WSE_OFF_WSTS3: nxt_rdata = wsts3_ff;
      `WSE_OFF_WEN1: nxt_rdata = wen1_ff;
      `WSE_OFF_WEN2: nxt_rdata = {1'b0, wen2_ff};
      `WSE_OFF_WEN3: nxt_rdata = wen3_ff;
      `WSE_OFF_MSTS1: nxt_rdata = msts1_ff;
      `WSE_OFF_MSTS2: nxt_rdata = msts2_view;
      `WSE_OFF_MEN1: nxt_rdata = men1_ff;
      `WSE_OFF_MEN2: nxt_rdata = men2_ff;
      `WSE_OFF_GP1: nxt_rdata = gpio_out_ff[7:0];
      `WSE_OFF_GP2: nxt_rdata = gpio_out_ff[15:8];
      `WSE_OFF_GP3: nxt_rdata = gpio_out_ff[23:16];
      `WSE_OFF_GP4: nxt_rdata = gpio_out_ff[31:24];
      default: nxt_rdata = 8'h00;
    endcase
  end

  // ****************************************
  // Standby domain state
  // ****************************************
  // Only the standby power-on reset reaches here; bus hard reset does not
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_sum_ff <= 1'b0;
      wake_gen_ff <= 1'b0;
      wsts1_ff <= `WSE_RST_ZERO;
      wsts2_ff <= 7'h00;
      wsts3_ff <= `WSE_RST_ZERO;
      wen1_ff <= `WSE_RST_ZERO;
      wen2_ff <= 7'h00;
      wen3_ff <= `WSE_RST_ZERO;
      msts1_ff <= `WSE_RST_ZERO;
      msts2_pin_ff <= 2'b00;
      men1_ff <= `WSE_RST_ZERO;
      men2_ff <= `WSE_RST_ZERO;
      gpio_out_ff <= 32'h0000_0000;
      gp_prev_ff <= 32'h0000_0000;
      ring_prev_ff <= 2'b11;
      mgmt_irq_group_ff <= 1'b0;
      irq2_slot_req_ff <= 1'b0;
      shared_mgmt_pin_out_ff <= 1'b0;
      shared_mgmt_pin_oe_ff <= 1'b0;
      wake_out_pin_out_ff <= 1'b0;
      wake_out_pin_oe_ff <= 1'b0;
    end else begin
      wake_sum_ff <= nxt_wake_sum;
      wsts1_ff <= nxt_wsts1;
      wsts2_ff <= nxt_wsts2;
      wsts3_ff <= nxt_wsts3;
      msts1_ff <= nxt_msts1;
      msts2_pin_ff <= nxt_msts2_pin;
      gp_prev_ff <= gp_eff;
      ring_prev_ff <= {ring_indicator_b_n, ring_indicator_a_n};
      if (we_wake_gen) begin
        wake_gen_ff <= io_wdata[0];
      end
      if (we_wen1) begin
        wen1_ff <= io_wdata;
      end
      if (we_wen2) begin
        wen2_ff <= io_wdata[6:0];
      end
      if (we_wen3) begin
        wen3_ff <= io_wdata;
      end
      if (we_men1) begin
        men1_ff <= io_wdata;
      end
      if (we_men2) begin
        men2_ff <= io_wdata;
      end
      if (we_gp1) begin
        gpio_out_ff[7:0] <= io_wdata;
      end
      if (we_gp2) begin
        gpio_out_ff[15:8] <= io_wdata;
      end
      if (we_gp3) begin
        gpio_out_ff[23:16] <= io_wdata;
      end
      if (we_gp4) begin
        gpio_out_ff[31:24] <= io_wdata;
      end
      mgmt_irq_group_ff <= nxt_group;
      irq2_slot_req_ff <= nxt_group & men2_ff[`WSE_M2_STREAM_ROUTE];
      // Pin released while the shared pin serves as plain GPIO
      shared_mgmt_pin_out_ff <= mgmt_drv[1];
      shared_mgmt_pin_oe_ff <= mgmt_drv[0] & shared_mgmt_pin_sel;
      wake_out_pin_out_ff <= wake_drv[1];
      wake_out_pin_oe_ff <= wake_drv[0];
    end
  end

  // ****************************************
  // Host read data
  // ****************************************
  // Read data is main-power side, so bus hard reset may clear it
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata_ff <= 8'h00;
      io_hit_ff <= 1'b0;
    end else if (bus_hard_reset_in) begin
      io_rdata_ff <= 8'h00;
      io_hit_ff <= 1'b0;
    end else begin
      io_hit_ff <= io_rd & hit;
      io_rdata_ff <= (io_rd & hit) ? nxt_rdata : 8'h00;
    end
  end

endmodule
`default_nettype wire

//--- rtl/wse_consts.vh
/*
  Constants for the wake and management-interrupt event logic: runtime
  register offsets, field positions, reset values and decode limits.
  Assumes it is included once per compile unit by its bare name.
*/
`ifndef WSE_CONSTS_VH
`define WSE_CONSTS_VH

// ****************************************
// Runtime register offsets
// ****************************************
`define WSE_OFF_WAKE_SUM 8'h00
`define WSE_OFF_WAKE_GEN 8'h01
`define WSE_OFF_WSTS1 8'h02
`define WSE_OFF_WSTS2 8'h03
`define WSE_OFF_WSTS3 8'h04
`define WSE_OFF_WEN1 8'h05
`define WSE_OFF_WEN2 8'h06
`define WSE_OFF_WEN3 8'h07
`define WSE_OFF_MSTS1 8'h08
`define WSE_OFF_MSTS2 8'h09
`define WSE_OFF_MEN2 8'h0b
`define WSE_OFF_GP1 8'h0c
`define WSE_OFF_GP2 8'h0d
`define WSE_OFF_GP3 8'h0e
`define WSE_OFF_GP4 8'h0f
`define WSE_OFF_MEN1 8'ha0

// ****************************************
// Reset values
// ****************************************
`define WSE_RST_ZERO 8'h00
`define WSE_RST_MSTS2 8'h01

// ****************************************
// Field positions
// ****************************************
// Management status/enable bank 2
`define WSE_M2_PRINTER 0
`define WSE_M2_UART_B 1
`define WSE_M2_UART_A 2
`define WSE_M2_FLOPPY 3
`define WSE_M2_GP23 4
`define WSE_M2_GP24 5
`define WSE_M2_STREAM_ROUTE 6
`define WSE_M2_PIN_ROUTE 7
// Wake bank 2: GP20..GP24 in bits 4:0, ring inputs above
`define WSE_W2_RING_A 5
`define WSE_W2_RING_B 6
// Configuration bits
`define WSE_POL1_MGMT_PIN 2
`define WSE_POL2_WAKE_PIN 5
`define WSE_DRV_MGMT_PIN 2
`define WSE_DRV_WAKE_PIN 7

// ****************************************
// Runtime block decode
// ****************************************
`define WSE_BASE_MIN 12'h100

`endif

//--- tb/wse_event_logic_asserts.sv
/*
  Port checker for the wake and management-interrupt event logic.
  Assumes it is bound to wse_event_logic and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module wse_event_logic_chk (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Host access
  input wire bus_hard_reset_in,
  input wire [15:0] io_addr,
  input wire io_rd,
  input wire [7:0] io_rdata_ff,
  input wire io_hit_ff,
  input wire [11:0] runtime_base_config,
  // Configuration
  input wire [7:0] gpio_polarity_config1,
  input wire [7:0] gpio_driver_type_config,
  input wire shared_mgmt_pin_sel,
  // Outputs
  input wire mgmt_irq_group_ff,
  input wire irq2_slot_req_ff,
  input wire shared_mgmt_pin_out_ff,
  input wire shared_mgmt_pin_oe_ff,
  input wire wake_out_pin_out_ff,
  input wire wake_out_pin_oe_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ****
  // Sequences
  // ****
  sequence s_rd_in_block;
    io_rd && !bus_hard_reset_in && io_addr[15:12] == 4'h0 &&
      runtime_base_config >= 12'h100 &&
      io_addr[11:4] == runtime_base_config[11:4];
  endsequence
  // Pin value lags its config by one edge, so wait for a settled config
  sequence s_cfg_held;
    $stable(gpio_driver_type_config) && $stable(gpio_polarity_config1);
  endsequence
  // ****
  // Assertions
  // ****
  a_hit_block: assert property (s_rd_in_block |=> io_hit_ff)
    else $error("decoded read gave no hit");
  a_hit_upper: assert property (
    io_rd && io_addr[15:12] != 4'h0 |=> !io_hit_ff)
    else $error("hit with upper address bits set");
  a_base_low: assert property (
    io_rd && runtime_base_config < 12'h100 |=> !io_hit_ff)
    else $error("hit with base below range");
  a_hit_pulse: assert property (io_hit_ff |-> $past(io_rd))
    else $error("hit without a read");
  a_data_hit: assert property (io_rdata_ff != 8'h00 |-> io_hit_ff)
    else $error("read data without a hit");
  a_slot_group: assert property (
    irq2_slot_req_ff |-> mgmt_irq_group_ff)
    else $error("slot request without group");
  a_pin_group: assert property (
    s_cfg_held ##0 (shared_mgmt_pin_oe_ff &&
      shared_mgmt_pin_out_ff == gpio_polarity_config1[2])
    |-> $past(mgmt_irq_group_ff))
    else $error("mgmt pin asserted without group");
  a_mgmt_od: assert property (
    !gpio_driver_type_config[2] |=> !shared_mgmt_pin_out_ff)
    else $error("open drain mgmt pin drove high");
  a_mgmt_pp: assert property (
    gpio_driver_type_config[2] && shared_mgmt_pin_sel
    |=> shared_mgmt_pin_oe_ff)
    else $error("push-pull mgmt pin not driven");
  a_wake_od: assert property (
    !gpio_driver_type_config[7] |=> !wake_out_pin_out_ff)
    else $error("open drain wake pin drove high");
  a_wake_pp: assert property (
    gpio_driver_type_config[7] |=> wake_out_pin_oe_ff)
    else $error("push-pull wake pin not driven");
endmodule
bind wse_event_logic wse_event_logic_chk u_chk (
  .clk(clk), .reset_n(reset_n), .bus_hard_reset_in(bus_hard_reset_in),
  .io_addr(io_addr), .io_rd(io_rd), .io_rdata_ff(io_rdata_ff),
  .io_hit_ff(io_hit_ff), .runtime_base_config(runtime_base_config),
  .gpio_polarity_config1(gpio_polarity_config1),
  .gpio_driver_type_config(gpio_driver_type_config),
  .shared_mgmt_pin_sel(shared_mgmt_pin_sel),
  .mgmt_irq_group_ff(mgmt_irq_group_ff),
  .irq2_slot_req_ff(irq2_slot_req_ff),
  .shared_mgmt_pin_out_ff(shared_mgmt_pin_out_ff),
  .shared_mgmt_pin_oe_ff(shared_mgmt_pin_oe_ff),
  .wake_out_pin_out_ff(wake_out_pin_out_ff),
  .wake_out_pin_oe_ff(wake_out_pin_oe_ff));
`default_nettype wire

//--- tb/wse_chipset_model.sv
/*
  Chipset side of the two event pins: pull-ups on the shared wires.
  Assumes each pin is driven only by the block under test.
*/
`timescale 1ns/10ps
`default_nettype none
module wse_chipset_model (
  // Pin drives from the block
  input wire mgmt_out,
  input wire mgmt_oe,
  input wire wake_out,
  input wire wake_oe,
  // Resolved wire levels
  output wire mgmt_level,
  output wire wake_level
);
  // Released pins float up, so open drain reads high when idle
  assign mgmt_level = mgmt_oe ? mgmt_out : 1'b1;
  assign wake_level = wake_oe ? wake_out : 1'b1;
endmodule
`default_nettype wire

//--- tb/test_wse_event_logic.sv
/*
  Testbench for the event logic: registers, pin and device events.
  Assumes the bound checker and the chipset pull-up model.
*/
`timescale 1ns/10ps
`default_nettype none
module test_wse_event_logic;
  localparam logic [11:0] BASE = 12'h2a0;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic bus_hard_reset_in = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [11:0] base_cfg = BASE;
  logic [7:0] pol1 = 8'h00;
  logic [7:0] pol2 = 8'h00;
  logic [7:0] drv = 8'h00;
  logic pin_sel = 1'b0;
  logic [31:0] gpio_in = 32'h0;
  logic prn_pwr = 1'b0;
  logic [3:0] src = 4'h0;
  logic ring_a_n = 1'b1;
  logic ring_b_n = 1'b1;
  wire [7:0] rdata;
  wire hit;
  wire [31:0] gpio_out;
  wire group;
  wire slot;
  wire m_out, m_oe, w_out, w_oe, mgmt_level, wake_level;
  integer errors = 0;
  integer checked = 0;
  integer seed = 1749;
  integer i;
  logic [31:0] v;
  logic [15:0] a;
  logic [7:0] wv [0:9];
  logic [11:0] ro [0:9] = '{12'h001, 12'h005, 12'h006, 12'h007, 12'h00b,
    12'h00c, 12'h00d, 12'h00e, 12'h00f, 12'h0a0};
  logic [7:0] rm [0:9] = '{8'h01, 8'hff, 8'h7f, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

  wse_event_logic u_wse_event_logic (
    .clk(clk), .reset_n(reset_n), .bus_hard_reset_in(bus_hard_reset_in),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata_ff(rdata), .io_hit_ff(hit), .runtime_base_config(base_cfg),
    .gpio_polarity_config1(pol1), .gpio_polarity_config2(pol2),
    .gpio_polarity_config3(8'h00), .gpio_driver_type_config(drv),
    .shared_mgmt_pin_sel(pin_sel), .gpio_in(gpio_in),
    .ring_indicator_a_n(ring_a_n), .ring_indicator_b_n(ring_b_n),
    .printer_port_powered(prn_pwr), .printer_acknowledge_in(src[0]),
    .uart_b_irq(src[1]), .uart_a_irq(src[2]), .floppy_irq(src[3]),
    .gpio_out_ff(gpio_out), .mgmt_irq_group_ff(group),
    .irq2_slot_req_ff(slot), .shared_mgmt_pin_out_ff(m_out),
    .shared_mgmt_pin_oe_ff(m_oe), .wake_out_pin_out_ff(w_out),
    .wake_out_pin_oe_ff(w_oe));
  wse_chipset_model u_wse_chipset_model (
    .mgmt_out(m_out), .mgmt_oe(m_oe), .wake_out(w_out), .wake_oe(w_oe),
    .mgmt_level(mgmt_level), .wake_level(wake_level));

  always #20 clk = ~clk;
  // ****
  // Tasks
  // ****
  task automatic check8(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check1(input string nm, input logic e, input logic g);
    check8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic io(input logic w, input logic [15:0] ad,
    input logic [7:0] d);
    @(posedge clk);
    io_addr <= ad;
    io_wdata <= d;
    io_wr <= w;
    io_rd <= !w;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [11:0] o, input logic [7:0] d);
    io(1'b1, {4'h0, BASE + o}, d);
  endtask
  task automatic rd(input logic [11:0] o, input logic [7:0] e);
    io(1'b0, {4'h0, BASE + o}, 8'h00);
    check8("rdata", e, rdata);
  endtask
  task automatic settle;
    repeat (5) @(posedge clk);
    #1;
  endtask
  function automatic logic exp_hit(input logic [15:0] x);
    return x[15:12] == 4'h0 && base_cfg >= 12'h100 &&
      (x[11:4] == base_cfg[11:4] ||
      (x[11:4] == base_cfg[11:4] + 8'h0a && x[3:0] == 4'h0));
  endfunction
  task automatic stop_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    #(40 * 20000);
    errors++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 0; i < 17; i++)
      rd(i == 16 ? 12'h0a0 : i[11:0], i == 9 ? 8'h01 : 8'h00);
    for (i = 0; i < 10; i++) begin
      v = $random(seed);
      wv[i] = v[7:0];
      wr(ro[i], wv[i]);
      rd(ro[i], wv[i] & rm[i]);
    end
    for (i = 0; i < 4; i++)
      check8("gpio_out", wv[5 + i], gpio_out[8 * i +: 8]);
    bus_hard_reset_in <= 1'b1;
    repeat (2) @(posedge clk);
    bus_hard_reset_in <= 1'b0;
    rd(12'h00c, wv[5]);
    for (i = 0; i < 10; i++)
      wr(ro[i], 8'h00);
    for (i = 0; i < 40; i++) begin
      v = $random(seed);
      base_cfg <= (i < 20) ? BASE : 12'h0f0;
      a = {v[16] ? v[15:12] : 4'h0, BASE[11:4] + {6'h00, v[5:4]}, v[3:0]};
      io(1'b0, a, 8'h00);
      check1("hit", exp_hit(a), hit);
    end
    base_cfg <= BASE;
    pin_sel <= 1'b1;
    drv <= 8'h04;
    wr(12'h00b, 8'hc0);
    wr(12'h0a0, 8'h01);
    wr(12'h005, 8'h03);
    gpio_in <= 32'h3;
    settle;
    gpio_in <= 32'h0;
    settle;
    rd(12'h008, 8'h03);
    rd(12'h002, 8'h03);
    rd(12'h000, 8'h01);
    check1("group", 1'b1, group);
    check1("slot", 1'b1, slot);
    check1("mgmt_pin", 1'b0, mgmt_level);
    check1("wake_pin", 1'b1, wake_level);
    wr(12'h008, 8'h01);
    settle;
    check1("group", 1'b0, group);
    wr(12'h0a0, 8'h02);
    settle;
    check1("group", 1'b1, group);
    wr(12'h008, 8'h00);
    rd(12'h008, 8'h02);
    wr(12'h008, 8'h02);
    settle;
    check1("group", 1'b0, group);
    check1("mgmt_pin", 1'b1, mgmt_level);
    wr(12'h001, 8'h01);
    settle;
    check1("wake_pin", 1'b0, wake_level);
    drv <= 8'h84;
    pol2 <= 8'h20;
    settle;
    check1("wake_pin", 1'b1, wake_level);
    wr(12'h000, 8'h01);
    rd(12'h000, 8'h01);
    wr(12'h002, 8'h03);
    wr(12'h000, 8'h00);
    rd(12'h000, 8'h01);
    wr(12'h000, 8'h01);
    rd(12'h000, 8'h00);
    settle;
    check1("wake_pin", 1'b0, wake_level);
    pol1 <= 8'h08;
    settle;
    wr(12'h008, 8'hff);
    gpio_in <= 32'h8;
    settle;
    rd(12'h008, 8'h00);
    gpio_in <= 32'h0;
    settle;
    rd(12'h008, 8'h08);
    prn_pwr <= 1'b1;
    wr(12'h00b, 8'h8f);
    for (i = 0; i < 4; i++) begin
      src <= 4'h1 << i;
      repeat (2) @(posedge clk);
      #1;
      check1("group", 1'b1, group);
      wr(12'h009, 8'h0f);
      rd(12'h009, 8'h01 << i);
      src <= 4'h0;
      repeat (2) @(posedge clk);
      #1;
      check1("group", 1'b0, group);
    end
    ring_a_n <= 1'b0;
    ring_b_n <= 1'b0;
    wr(12'h006, 8'h20);
    settle;
    ring_a_n <= 1'b1;
    ring_b_n <= 1'b1;
    settle;
    rd(12'h003, 8'h60);
    rd(12'h000, 8'h01);
    check1("wake_pin", 1'b1, wake_level);
    stop_test;
  end
endmodule
`default_nettype wire
